// ---- hdl/pump_run_mode_control.sv ----
// Run control of the pump: source arbitration, restart policy and indicators.
//
// Notes on behaviour
// - Three sources; only the selected mode governs.
// - Local running needs cover plug bridge present.
// - Local switch on starts pump automatically.
// - Start enables purge on either variant; vapour variant adds ballast.
// - Local/remote restart after power returns.
// - Local/remote resume after emergency stop release.
// - Remote: contact closed starts at contact speed.
// - Contact closed: serial run commands get context error.
// - Serial run-on starts at serial speed.
// - Serial run-off stops the pump.
// - Serial run: contact close then open stops.
// - Serial: no restart after emergency stop.
// - Blue lit steadily while powered.
// - Green flashes ramping, steady at speed.
// - Red off, flash debonding, steady blocking fault.
`timescale 1ns/1ps
`include "run_mode_params.svh"
module pump_run_mode_control (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire run_mode_pkg::mode_t mode_sel,
	input wire logic main_switch_pin,
	input wire logic cover_plug_pin,
	input wire logic start_stop_contact_pin,
	input wire logic estop_pin,
	input wire logic power_good,
	input wire logic condensable_vapour_variant,
	input wire logic purge_variant,
	input wire run_mode_pkg::speed_t contact_speed,
	input wire run_mode_pkg::speed_t serial_speed,
	input wire logic run_on_command,
	input wire logic run_off_command,
	input wire logic speed_reached,
	input wire logic debond_active,
	input wire logic fault_block,
	output logic motor_run,
	output run_mode_pkg::speed_t speed_setpoint,
	output logic purge_on,
	output logic ballast_on,
	output logic reply_valid,
	output logic [1:0] reply_code,
	output logic led_blue,
	output logic led_green,
	output logic led_red
);
	import run_mode_pkg::*;

	logic sw_lvl; // Filtered main switch.
	logic plug_lvl; // Filtered cover plug bridge.
	logic ss_lvl; // Filtered start/stop contact.
	logic estop_lvl; // Filtered emergency stop, high while asserted.
	logic ss_prev_r; // Contact level last cycle.
	logic serial_latch_r; // Serial run-on in effect.
	logic serial_latch_nxt;
	run_state_e state_r; // Drive state.
	run_state_e state_nxt;
	logic [`FLASH_CNT_W-1:0] flash_cnt_r; // Flash divider.
	logic flash_r; // Flash phase.
	logic motor_run_r;
	speed_t speed_r;
	logic purge_r;
	logic ballast_r;
	logic reply_valid_r;
	logic [1:0] reply_code_r;
	logic blue_r;
	logic green_r;
	logic red_r;

	// Each pin comes from outside and is filtered before use.
	pin_sync u_sw (.ref_clk(ref_clk), .rstn(rstn), .pin(main_switch_pin), .level(sw_lvl));
	pin_sync u_plug (.ref_clk(ref_clk), .rstn(rstn), .pin(cover_plug_pin), .level(plug_lvl));
	pin_sync u_ss (.ref_clk(ref_clk), .rstn(rstn), .pin(start_stop_contact_pin), .level(ss_lvl));
	pin_sync u_es (.ref_clk(ref_clk), .rstn(rstn), .pin(estop_pin), .level(estop_lvl));

	wire is_local = (mode_sel == `MODE_LOCAL);
	wire is_remote = (mode_sel == `MODE_REMOTE);
	wire is_serial = (mode_sel == `MODE_SERIAL);
	wire ss_fall = ss_prev_r & ~ss_lvl; // Contact just opened.
	wire any_cmd = run_on_command | run_off_command;
	// Serial commands are refused while the contact is closed.
	wire cmd_refused = any_cmd & ss_lvl;
	wire cmd_accept = any_cmd & ~ss_lvl & is_serial;
	wire power_ok = power_good & sw_lvl;
	// Local and remote demand are level-based, so they return after power or stop.
	wire local_demand = is_local & sw_lvl & plug_lvl;
	wire remote_demand = is_remote & ss_lvl;
	wire serial_demand = is_serial & serial_latch_r;
	wire demand = power_ok & ~estop_lvl & ~fault_block &
		(local_demand | remote_demand | serial_demand);
	wire flash_wrap = (flash_cnt_r == `FLASH_CNT_W'(`FLASH_HALF_CYC - 1));
	wire speed_t sel_speed = is_serial ? serial_speed : contact_speed;

	// Serial run latch: set by run-on, cleared by run-off, stop, contact release or power loss.
	always_comb begin
		serial_latch_nxt = serial_latch_r;
		if (!is_serial || !power_ok) begin
			serial_latch_nxt = 1'b0;
		end else if (estop_lvl) begin
			// Latch drops so release needs a fresh run-on.
			serial_latch_nxt = 1'b0;
		end else if (ss_fall) begin
			serial_latch_nxt = 1'b0;
		end else if (cmd_accept && run_off_command) begin
			serial_latch_nxt = 1'b0;
		end else if (cmd_accept && run_on_command) begin
			serial_latch_nxt = 1'b1;
		end
	end

	// Drive state: ramp until speed reached, drop to idle when demand ends.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (demand) begin
					state_nxt = ST_RAMP;
				end
			end
			ST_RAMP: begin
				if (!demand) begin
					state_nxt = ST_IDLE;
				end else if (speed_reached) begin
					state_nxt = ST_AT_SPEED;
				end
			end
			ST_AT_SPEED: begin
				if (!demand) begin
					state_nxt = ST_IDLE;
				end else if (!speed_reached) begin
					state_nxt = ST_RAMP;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// State, latch and contact history.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
			serial_latch_r <= 1'b0;
			ss_prev_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			serial_latch_r <= serial_latch_nxt;
			ss_prev_r <= ss_lvl;
		end
	end

	// Flash divider gives a phase toggle every half period.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			flash_cnt_r <= '0;
			flash_r <= 1'b0;
		end else if (flash_wrap) begin
			flash_cnt_r <= '0;
			flash_r <= ~flash_r;
		end else begin
			flash_cnt_r <= flash_cnt_r + `FLASH_CNT_W'(1);
		end
	end

	// Run, purge and ballast follow the next state; speed is the serial speed in serial mode, the contact speed otherwise.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			motor_run_r <= 1'b0;
			speed_r <= '0;
			purge_r <= 1'b0;
			ballast_r <= 1'b0;
		end else begin
			motor_run_r <= (state_nxt != ST_IDLE);
			speed_r <= sel_speed;
			// Purge on either gas variant, ballast only on the vapour variant.
			purge_r <= (state_nxt != ST_IDLE) & (purge_variant | condensable_vapour_variant);
			ballast_r <= (state_nxt != ST_IDLE) & condensable_vapour_variant;
		end
	end

	// One-cycle reply to every serial command.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			reply_valid_r <= 1'b0;
			reply_code_r <= 2'h0;
		end else begin
			reply_valid_r <= any_cmd;
			if (cmd_refused) begin
				reply_code_r <= `REPLY_CONTEXT_ERR;
			end else if (any_cmd) begin
				reply_code_r <= `REPLY_OK;
			end
		end
	end

	// Indicators.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			blue_r <= 1'b0;
			green_r <= 1'b0;
			red_r <= 1'b0;
		end else begin
			blue_r <= power_ok;
			case (state_r)
				ST_RAMP: green_r <= flash_r;
				ST_AT_SPEED: green_r <= 1'b1;
				default: green_r <= 1'b0;
			endcase
			if (fault_block) begin
				red_r <= 1'b1;
			end else if (debond_active) begin
				red_r <= flash_r;
			end else begin
				red_r <= 1'b0;
			end
		end
	end

	assign motor_run = motor_run_r;
	assign speed_setpoint = speed_r;
	assign purge_on = purge_r;
	assign ballast_on = ballast_r;
	assign reply_valid = reply_valid_r;
	assign reply_code = reply_code_r;
	assign led_blue = blue_r;
	assign led_green = green_r;
	assign led_red = red_r;
endmodule

// ---- hdl/run_mode_params.svh ----
// Constants for the pump run mode controller.
`ifndef RUN_MODE_PARAMS_SVH
`define RUN_MODE_PARAMS_SVH
// Clock rate in hertz.
`define CLK_HZ 25000000
// Flash half period in milliseconds.
`define FLASH_HALF_MS 500
// Flash half period in clock cycles.
`define FLASH_HALF_CYC ((`CLK_HZ / 1000) * `FLASH_HALF_MS)
// Width of the flash divider counter.
`define FLASH_CNT_W 24
// Mode select codes.
`define MODE_LOCAL 2'h0
`define MODE_REMOTE 2'h1
`define MODE_SERIAL 2'h2
// Reply codes for serial commands.
`define REPLY_OK 2'h1
`define REPLY_CONTEXT_ERR 2'h2
`endif

// ---- hdl/run_mode_pkg.sv ----
// Types shared by the pump run mode controller.
package run_mode_pkg;
	// Run state of the motor drive.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RAMP,
		ST_AT_SPEED
	} run_state_e;
	// Two-bit mode select.
	typedef logic [1:0] mode_t;
	// Speed word.
	typedef logic [7:0] speed_t;
endpackage

// ---- hdl/pin_sync.sv ----
// Three-stage synchroniser with agreement filter for one pin.
`timescale 1ns/1ps
module pin_sync (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic pin,
	output logic level
);
	logic stage1_r; // First stage, read only by s2_r.
	logic s2_r; // Second stage.
	logic s3_r; // Third stage.
	logic level_r; // Filtered level.
	assign level = level_r;
	// Shift the pin through three stages; accept a change when stages two and three agree.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			stage1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			level_r <= 1'b0;
		end else begin
			stage1_r <= pin;
			s2_r <= stage1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level_r <= s3_r;
			end
		end
	end
endmodule

// ---- test/run_ctrl_asserts.sv ----
// Port-level checks on the pump run controller.
`timescale 1ns/1ps
module run_ctrl_checker (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire run_mode_pkg::mode_t mode_sel,
	input wire logic estop_pin,
	input wire logic power_good,
	input wire logic main_switch_pin,
	input wire logic condensable_vapour_variant,
	input wire logic run_on_command,
	input wire logic run_off_command,
	input wire logic fault_block,
	input wire logic motor_run,
	input wire logic ballast_on,
	input wire logic reply_valid,
	input wire logic led_blue,
	input wire logic led_red
);
	import run_mode_pkg::*;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	a_reply_per_cmd: assert property ((run_on_command || run_off_command) |=> reply_valid)
		else $error("command got no reply");
	a_no_stray_reply: assert property (!(run_on_command || run_off_command) |=> !reply_valid)
		else $error("reply without command");
	// The switch pin needs two agreeing filter samples before the lamp can follow it.
	a_blue_on: assert property ($past(rstn) && $past(rstn, 2) && $past(rstn, 3) && $past(rstn, 4) &&
		$past(rstn, 5) && $past(power_good) && $past(main_switch_pin, 4) &&
		$past(main_switch_pin, 5) |-> led_blue)
		else $error("blue lamp dark while powered");
	// Loss of mains darkens the lamp one edge later.
	a_blue_off: assert property ($past(rstn) && !$past(power_good) |-> !led_blue)
		else $error("blue lamp lit while unpowered");
	a_red_fault: assert property ($past(rstn) && $past(fault_block) |-> led_red)
		else $error("red lamp not lit on fault");
	a_fault_halts: assert property ($past(rstn) && $past(fault_block) |-> !motor_run)
		else $error("running with blocking fault");
	a_estop_halts: assert property (estop_pin [*7] |-> !motor_run)
		else $error("running during stop");
	a_mode_none: assert property ($past(rstn) && $past(mode_sel) == 2'h3 |-> !motor_run)
		else $error("running with no source");
	a_ballast_vapour: assert property (ballast_on |-> motor_run && $past(condensable_vapour_variant))
		else $error("ballast on wrongly");
endmodule
bind pump_run_mode_control run_ctrl_checker i_run_ctrl_checker (.ref_clk, .rstn, .mode_sel,
	.estop_pin, .power_good, .main_switch_pin, .condensable_vapour_variant, .run_on_command,
	.run_off_command, .fault_block, .motor_run, .ballast_on, .reply_valid, .led_blue, .led_red);

// ---- test/host_model.sv ----
// Host equipment model: contact wiring and serial master.
`timescale 1ns/1ps
module host_model (
	input wire logic ref_clk,
	input wire logic reply_valid,
	input wire logic [1:0] reply_code,
	output logic main_switch_pin,
	output logic cover_plug_pin,
	output logic start_stop_contact_pin,
	output logic estop_pin,
	output logic power_good,
	output logic run_on_command,
	output logic run_off_command,
	output run_mode_pkg::speed_t contact_speed,
	output run_mode_pkg::speed_t serial_speed
);
	import run_mode_pkg::*;
	// Distinct speeds, both above the low band, so a wrong source shows.
	assign contact_speed = 8'h50;
	assign serial_speed = 8'h46;
	initial begin
		{main_switch_pin, cover_plug_pin, start_stop_contact_pin, estop_pin} = 4'h0;
		{power_good, run_on_command, run_off_command} = 3'h0;
	end
	// Levels change between edges; each call drives the plug too, and it starts unfitted.
	task automatic pins(input logic sw, plug, contact, stop, pg);
		@(negedge ref_clk);
		main_switch_pin = sw;
		cover_plug_pin = plug;
		start_stop_contact_pin = contact;
		estop_pin = stop;
		power_good = pg;
	endtask
	// One-cycle command; the reply code is read at the next falling edge.
	task automatic cmd(input logic on, output logic [1:0] code);
		@(negedge ref_clk);
		run_on_command = on;
		run_off_command = !on;
		@(negedge ref_clk);
		code = reply_valid ? reply_code : 2'h0;
		run_on_command = 1'b0;
		run_off_command = 1'b0;
	endtask
endmodule

// ---- test/test_pump_run_mode_control.sv ----
// Self-checking bench for the pump run controller.
`timescale 1ns/1ps
`include "run_mode_params.svh"
module test_pump_run_mode_control;
	import run_mode_pkg::*;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	mode_t mode_sel = 2'h3;
	logic vapour = 1'b0; // Condensable vapour variant strap.
	logic pv = 1'b1; // Purge variant strap.
	logic sr = 1'b0;
	logic fault_block = 1'b0;
	logic sw, plug, ssc, estop_pin, power_good, on_c, off_c, motor_run, purge_on, ballast_on;
	logic reply_valid, led_blue, led_green, led_red;
	logic [1:0] reply_code, code;
	speed_t c_spd, s_spd, speed_setpoint;
	int err_total = 0;
	int n_checks = 0;
	always #20 ref_clk = ~ref_clk;
	pump_run_mode_control i_pump_run_mode_control (.ref_clk, .rstn, .mode_sel,
		.main_switch_pin(sw), .cover_plug_pin(plug), .start_stop_contact_pin(ssc), .estop_pin,
		.power_good, .condensable_vapour_variant(vapour), .purge_variant(pv), .contact_speed(c_spd),
		.serial_speed(s_spd), .run_on_command(on_c), .run_off_command(off_c), .speed_reached(sr),
		.debond_active(1'b0), .fault_block, .motor_run, .speed_setpoint, .purge_on, .ballast_on,
		.reply_valid, .reply_code, .led_blue, .led_green, .led_red);
	host_model i_host_model (.ref_clk, .reply_valid, .reply_code, .main_switch_pin(sw),
		.cover_plug_pin(plug), .start_stop_contact_pin(ssc), .estop_pin, .power_good,
		.run_on_command(on_c), .run_off_command(off_c), .contact_speed(c_spd), .serial_speed(s_spd));
	task automatic chk(input string what, input logic [7:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Local switch, plug removal, stop and mains loss.
	task automatic t_local;
		mode_sel = `MODE_LOCAL;
		vapour = 1'b1;
		i_host_model.pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		w(8);
		chk("blue", led_blue, 1'b1);
		chk("run", motor_run, 1'b1);
		chk("purge", purge_on, 1'b1);
		chk("ballast", ballast_on, 1'b1);
		i_host_model.pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		w(8);
		chk("no plug", motor_run, 1'b0);
		i_host_model.pins(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
		w(8);
		chk("unpowered", led_blue, 1'b0);
		i_host_model.pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		w(8);
		chk("restart", motor_run, 1'b1);
	endtask
	// Contact start; serial commands refused while it is closed.
	task automatic t_remote;
		mode_sel = `MODE_REMOTE;
		vapour = 1'b0;
		i_host_model.pins(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
		w(8);
		chk("speed", speed_setpoint, 8'h50);
		chk("r purge", purge_on, 1'b1);
		chk("r ballast", ballast_on, 1'b0);
		for (int k = 0; k < 2; k++) begin
			i_host_model.cmd(k[0], code);
			chk("refused", code, `REPLY_CONTEXT_ERR);
			chk("kept", motor_run, 1'b1);
		end
		i_host_model.pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		w(8);
		chk("opened", motor_run, 1'b0);
	endtask
	task automatic t_serial;
		mode_sel = `MODE_SERIAL;
		pv = 1'b0;
		w(8);
		i_host_model.cmd(1'b1, code);
		chk("ok", code, `REPLY_OK);
		w(2);
		chk("s run", motor_run, 1'b1);
		chk("s speed", speed_setpoint, 8'h46);
		chk("s purge", purge_on, 1'b0);
		chk("s ballast", ballast_on, 1'b0);
		sr = 1'b1;
		w(3);
		chk("green", led_green, 1'b1);
		i_host_model.cmd(1'b0, code);
		w(2);
		chk("off", motor_run, 1'b0);
		i_host_model.cmd(1'b1, code);
		i_host_model.pins(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
		w(8);
		chk("on again", motor_run, 1'b1);
		i_host_model.pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		w(8);
		chk("reopen", motor_run, 1'b0);
		i_host_model.cmd(1'b1, code);
		w(1);
		chk("s rerun", motor_run, 1'b1);
		i_host_model.pins(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
		w(8);
		i_host_model.pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		w(8);
		chk("no resume", motor_run, 1'b0);
		fault_block = 1'b1;
		i_host_model.cmd(1'b1, code);
		w(3);
		chk("red", led_red, 1'b1);
		chk("blocked", motor_run, 1'b0);
	endtask
	initial begin
		w(16);
		rstn = 1'b1;
		w(2);
		t_local;
		t_remote;
		t_serial;
		results;
	end
	// The run needs some 140 cycles; this cuts a hang well after that.
	initial begin
		#100000;
		err_total++;
		results;
	end
endmodule
